// file: pkg/pwmdz_pkg.sv
// Purpose: shared constants for the four-channel pwm with dead-zone pairs
// Assumes: one 40 MHz clock, plain register port with 32-bit data
// Notes: registers sit at word offsets; channel blocks repeat every 16 bytes
//
// Function
// - four pwm channels, zero to three, each able to run on its own.
// - channels pair as zero/one and two/three, each pair with a dead-zone generator.
// - each pair owns one 8-bit prescaler feeding both channels through a divider.
// - divider offers prescaler output divided by 1, 2, 4, 8 or 16.
// - every channel picks its divided clock with its own selector.
// - each channel has a 16-bit down-counter; one countdown is one period.
// - a 16-bit comparator checks the count against a loaded threshold.
// - output level toggles when the count becomes equal to the threshold.
// - dead-zone generators step on the divided channel clock.
// - with dead-zone enabled, both pair pins carry the generator's outputs.
// - reload and compare values are double-buffered so writes never glitch output.
// - a channel raises its interrupt when its counter reaches zero.
// - periodic mode reloads from the buffer at zero and keeps going.
// - one-shot mode halts at zero and raises exactly one interrupt.
// - all counting logic runs on the single peripheral bus clock.
// - each channel works as an interval timer with its own interrupt.
package pwmdz_pkg;
  localparam int NCH = 4;
  localparam int NPAIR = 2;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int CW = 16;
  localparam int PW = 8;

  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_PRE = 8'h04;
  localparam logic [AW-1:0] OFS_SEL = 8'h08;
  localparam logic [AW-1:0] OFS_DZ = 8'h0C;
  localparam logic [AW-1:0] OFS_IEN = 8'h10;
  localparam logic [AW-1:0] OFS_IFLAG = 8'h14;
  localparam logic [AW-1:0] OFS_CH_BASE = 8'h40;

  localparam logic [1:0] FLD_RELOAD = 2'h0;
  localparam logic [1:0] FLD_CMP = 2'h1;
  localparam logic [1:0] FLD_COUNT = 2'h2;

  localparam int CTRL_EN_POS = 0;
  localparam int CTRL_PER_POS = 4;
  localparam int CTRL_DZ_POS = 8;
  localparam int SEL_STRIDE = 4;
  localparam int PAIR_STRIDE = 8;
  localparam logic [2:0] SEL_MAX = 3'h4;

  localparam logic [CW-1:0] RST_RELOAD = 16'h0000;
  localparam logic [CW-1:0] RST_CMP = 16'h0000;
  localparam logic [PW-1:0] RST_PRE = 8'h00;
  localparam logic [PW-1:0] RST_DZ = 8'h00;
endpackage

// file: pkg/pwmdz_dz_if.sv
// Purpose: link between the channel core and one dead-zone generator
// Assumes: same clock on both sides
// Notes: tick is a one-cycle pulse of the base channel's divided clock
`timescale 1ns/1ps
`default_nettype none
interface pwmdz_dz_if;
  logic tick;
  logic base;
  logic [7:0] len;
  logic pin_a;
  logic pin_b;
  modport ctl(output tick, output base, output len, input pin_a, input pin_b);
  modport dz(input tick, input base, input len, output pin_a, output pin_b);
endinterface
`default_nettype wire

// file: hdl/pwmdz_deadzone.sv
// Purpose: complementary output pair with a gap after every base edge
// Assumes: base changes only on the tick of its channel
// Notes: a gap length of zero gives plain complementary outputs
`timescale 1ns/1ps
`default_nettype none
module pwmdz_deadzone (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  pwmdz_dz_if.dz dz
);
  typedef struct packed {
    logic last;
    logic [7:0] cnt;
    logic a;
    logic b;
  } pwmdz_dz_s;

  pwmdz_dz_s s_ff;
  pwmdz_dz_s nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (dz.tick) begin
      nxt_s.last = dz.base;
      if (dz.base != s_ff.last) begin
        nxt_s.cnt = dz.len;
        nxt_s.a = (dz.len == 8'h00) ? dz.base : 1'b0;
        nxt_s.b = (dz.len == 8'h00) ? ~dz.base : 1'b0;
      end else if (s_ff.cnt > 8'h01) begin
        nxt_s.cnt = s_ff.cnt - 8'h01;
      end else begin
        nxt_s.cnt = 8'h00;
        nxt_s.a = dz.base;
        nxt_s.b = ~dz.base;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign dz.pin_a = s_ff.a;
  assign dz.pin_b = s_ff.b;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  a_dz_never_both: assert property (!(s_ff.a && s_ff.b))
    else $error("dead-zone outputs both active");
  a_dz_edge_gap: assert property (dz.tick && dz.base != s_ff.last && dz.len != 8'h00 |=> !s_ff.a && !s_ff.b)
    else $error("no gap after base edge");
endmodule
`default_nettype wire

// file: hdl/pwmdz_top.sv
// Purpose: four pwm channels with prescalers, dividers and dead-zone pairs
// Assumes: single-cycle strobes from the register master, one clock domain
// Notes: pins and read data are registered, so they trail the state by one cycle
`timescale 1ns/1ps
`default_nettype none
module pwmdz_top
  import pwmdz_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DW-1:0] rdata_out,
  output logic [NCH-1:0] pwm_out,
  output logic [NCH-1:0] ch_irq_out,
  output logic irq_out
);
  typedef struct packed {
    logic [NCH-1:0] en;
    logic [NCH-1:0] per;
    logic [NCH-1:0] run;
    logic [NCH-1:0] raw;
    logic [NCH-1:0] pin;
    logic [NCH-1:0] irq_f;
    logic [NCH-1:0] ien;
    logic [NPAIR-1:0] dz_en;
    logic [NPAIR-1:0][PW-1:0] pre;
    logic [NPAIR-1:0][PW-1:0] pre_cnt;
    logic [NPAIR-1:0][PW-1:0] dz_len;
    logic [NPAIR-1:0][3:0] div_cnt;
    logic [NCH-1:0][2:0] sel;
    logic [NCH-1:0][CW-1:0] rld_buf;
    logic [NCH-1:0][CW-1:0] cmp_buf;
    logic [NCH-1:0][CW-1:0] cmp;
    logic [NCH-1:0][CW-1:0] cnt;
    logic [DW-1:0] rdata;
  } pwmdz_state_s;

  pwmdz_state_s s_ff;
  pwmdz_state_s nxt_s;

  logic [NPAIR-1:0] ptick;
  logic [NCH-1:0] ctick;
  logic [NCH-1:0] wrap;
  logic [NCH-1:0] match;
  logic [NCH-1:0] dz_pin;
  logic ch_hit;
  logic [1:0] ch_idx;
  logic [1:0] ch_fld;

  assign ch_hit = (addr_in[7:6] == OFS_CH_BASE[7:6]);
  assign ch_idx = addr_in[5:4];
  assign ch_fld = addr_in[3:2];

  // clock tree: prescaler tick per pair, divided tick per channel
  always_comb begin
    logic [2:0] sel;
    logic [3:0] mask;
    sel = 3'h0;
    mask = 4'h0;
    // a count left above a freshly lowered prescale value ticks at once
    // instead of wrapping through all 256 steps first
    for (int p = 0; p < NPAIR; p++) begin
      ptick[p] = (s_ff.pre_cnt[p] >= s_ff.pre[p]);
    end
    for (int c = 0; c < NCH; c++) begin
      sel = (s_ff.sel[c] > SEL_MAX) ? SEL_MAX : s_ff.sel[c];
      mask = 4'((5'h01 << sel) - 5'h01);
      ctick[c] = ptick[c/2] && ((s_ff.div_cnt[c/2] & mask) == mask);
      wrap[c] = ctick[c] && s_ff.run[c] && (s_ff.cnt[c] == 16'h0000);
      match[c] = ctick[c] && s_ff.run[c] && (s_ff.cnt[c] != 16'h0000) &&
                 ((s_ff.cnt[c] - 16'h0001) == s_ff.cmp[c]);
    end
  end

  always_comb begin
    logic [NCH-1:0] clr;
    logic [NCH-1:0] new_en;
    clr = '0;
    new_en = '0;
    nxt_s = s_ff;

    // all counting runs straight off the bus clock, no derived clocks
    for (int p = 0; p < NPAIR; p++) begin
      if (ptick[p]) begin
        nxt_s.pre_cnt[p] = '0;
        nxt_s.div_cnt[p] = s_ff.div_cnt[p] + 4'h1;
      end else begin
        nxt_s.pre_cnt[p] = s_ff.pre_cnt[p] + 8'h01;
      end
    end

    for (int c = 0; c < NCH; c++) begin
      if (wrap[c]) begin
        if (s_ff.per[c]) begin
          // buffers move to the live copies at a period boundary and on the enable edge
          nxt_s.cnt[c] = s_ff.rld_buf[c];
          nxt_s.cmp[c] = s_ff.cmp_buf[c];
          nxt_s.raw[c] = 1'b1;
        end else begin
          nxt_s.run[c] = 1'b0;
        end
      end else if (ctick[c] && s_ff.run[c]) begin
        nxt_s.cnt[c] = s_ff.cnt[c] - 16'h0001;
        if (match[c]) begin
          nxt_s.raw[c] = ~s_ff.raw[c];
        end
      end
    end

    if (wr_in) begin
      if (ch_hit) begin
        unique case (ch_fld)
          FLD_RELOAD: nxt_s.rld_buf[ch_idx] = wdata_in[CW-1:0];
          FLD_CMP: nxt_s.cmp_buf[ch_idx] = wdata_in[CW-1:0];
          default: ;
        endcase
      end else begin
        unique case (addr_in)
          OFS_CTRL: begin
            new_en = wdata_in[CTRL_EN_POS +: NCH];
            nxt_s.en = new_en;
            nxt_s.per = wdata_in[CTRL_PER_POS +: NCH];
            nxt_s.dz_en = wdata_in[CTRL_DZ_POS +: NPAIR];
            for (int c = 0; c < NCH; c++) begin
              // each channel starts or stops on its own enable edge
              if (new_en[c] && !s_ff.en[c]) begin
                nxt_s.run[c] = 1'b1;
                nxt_s.cnt[c] = s_ff.rld_buf[c];
                nxt_s.cmp[c] = s_ff.cmp_buf[c];
                nxt_s.raw[c] = 1'b1;
              end else if (!new_en[c]) begin
                nxt_s.run[c] = 1'b0;
                nxt_s.raw[c] = 1'b0;
              end
            end
          end
          OFS_PRE: begin
            for (int p = 0; p < NPAIR; p++) begin
              nxt_s.pre[p] = wdata_in[p*PAIR_STRIDE +: PW];
            end
          end
          OFS_SEL: begin
            for (int c = 0; c < NCH; c++) begin
              nxt_s.sel[c] = wdata_in[c*SEL_STRIDE +: 3];
            end
          end
          OFS_DZ: begin
            for (int p = 0; p < NPAIR; p++) begin
              nxt_s.dz_len[p] = wdata_in[p*PAIR_STRIDE +: PW];
            end
          end
          OFS_IEN: nxt_s.ien = wdata_in[NCH-1:0];
          OFS_IFLAG: clr = wdata_in[NCH-1:0];
          default: ;
        endcase
      end
    end

    if (rd_in && !ch_hit && (addr_in == OFS_IFLAG)) begin
      clr = '1;
    end
    // a zero reached in the clearing cycle is kept, set beats clear
    nxt_s.irq_f = (s_ff.irq_f & ~clr) | wrap;

    for (int c = 0; c < NCH; c++) begin
      nxt_s.pin[c] = s_ff.dz_en[c/2] ? dz_pin[c] : s_ff.raw[c];
    end

    nxt_s.rdata = '0;
    if (rd_in) begin
      if (ch_hit) begin
        unique case (ch_fld)
          FLD_RELOAD: nxt_s.rdata[CW-1:0] = s_ff.rld_buf[ch_idx];
          FLD_CMP: nxt_s.rdata[CW-1:0] = s_ff.cmp_buf[ch_idx];
          FLD_COUNT: nxt_s.rdata[CW-1:0] = s_ff.cnt[ch_idx];
          default: ;
        endcase
      end else begin
        unique case (addr_in)
          OFS_CTRL: begin
            nxt_s.rdata[CTRL_EN_POS +: NCH] = s_ff.en;
            nxt_s.rdata[CTRL_PER_POS +: NCH] = s_ff.per;
            nxt_s.rdata[CTRL_DZ_POS +: NPAIR] = s_ff.dz_en;
          end
          OFS_PRE: begin
            for (int p = 0; p < NPAIR; p++) begin
              nxt_s.rdata[p*PAIR_STRIDE +: PW] = s_ff.pre[p];
            end
          end
          OFS_SEL: begin
            for (int c = 0; c < NCH; c++) begin
              nxt_s.rdata[c*SEL_STRIDE +: 3] = s_ff.sel[c];
            end
          end
          OFS_DZ: begin
            for (int p = 0; p < NPAIR; p++) begin
              nxt_s.rdata[p*PAIR_STRIDE +: PW] = s_ff.dz_len[p];
            end
          end
          OFS_IEN: nxt_s.rdata[NCH-1:0] = s_ff.ien;
          OFS_IFLAG: nxt_s.rdata[NCH-1:0] = s_ff.irq_f;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_ff <= '0;
      s_ff.rld_buf <= {NCH{RST_RELOAD}};
      s_ff.cmp_buf <= {NCH{RST_CMP}};
      s_ff.pre <= {NPAIR{RST_PRE}};
      s_ff.dz_len <= {NPAIR{RST_DZ}};
    end else begin
      s_ff <= nxt_s;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NPAIR; gp++) begin : g_pair
      pwmdz_dz_if dzi();
      assign dzi.tick = ctick[2*gp];
      assign dzi.base = s_ff.raw[2*gp];
      assign dzi.len = s_ff.dz_len[gp];
      assign dz_pin[2*gp] = dzi.pin_a;
      assign dz_pin[2*gp+1] = dzi.pin_b;
      pwmdz_deadzone u_dz (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .dz(dzi.dz)
      );
    end
  endgenerate

  assign rdata_out = s_ff.rdata;
  assign pwm_out = s_ff.pin;
  assign ch_irq_out = s_ff.irq_f & s_ff.ien;
  assign irq_out = |ch_irq_out;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_chk
      a_zero_flag: assert property (wrap[gc] |=> s_ff.irq_f[gc])
        else $error("flag not set at zero");
      a_period_reload: assert property (wrap[gc] && s_ff.per[gc] && !wr_in
          |=> s_ff.run[gc] && s_ff.cnt[gc] == $past(s_ff.rld_buf[gc]))
        else $error("periodic reload wrong");
      a_oneshot_halt: assert property (wrap[gc] && !s_ff.per[gc] && !wr_in
          |=> !s_ff.run[gc] && s_ff.cnt[gc] == 16'h0000)
        else $error("one-shot did not halt");
      a_oneshot_once: assert property ((wrap[gc] && !s_ff.per[gc]) ##1 !wr_in |=> !wrap[gc])
        else $error("second one-shot interrupt");
      a_match_toggle: assert property (match[gc] && !wr_in
          |=> s_ff.raw[gc] != $past(s_ff.raw[gc]))
        else $error("no toggle at compare match");
      a_cmp_buffered: assert property (!wrap[gc] && !(wr_in && !ch_hit && addr_in == OFS_CTRL)
          |=> s_ff.cmp[gc] == $past(s_ff.cmp[gc]))
        else $error("live compare changed mid period");
      a_flag_sticky: assert property (s_ff.irq_f[gc] && !rd_in && !wr_in |=> s_ff.irq_f[gc])
        else $error("flag dropped without clear");
      a_irq_gate: assert property ($rose(s_ff.irq_f[gc]) && s_ff.ien[gc] |-> irq_out && ch_irq_out[gc])
        else $error("enabled flag did not interrupt");
      a_pin_source: assert property (s_ff.dz_en[gc/2] |=> pwm_out[gc] == $past(dz_pin[gc]))
        else $error("pin not from dead-zone output");
    end
  endgenerate
endmodule
`default_nettype wire

// file: tb/pwmdz_power_stage.sv
// Purpose: model of the off-chip half bridge driven by one complementary pair
// Assumes: high and low side switches follow the pins with no delay
// Notes: a real bridge shorts the rail when both switches conduct, so that is counted
`timescale 1ns/1ps
`default_nettype none
module pwmdz_power_stage (
  input wire logic clk_sys_in,
  input wire logic hi_in,
  input wire logic lo_in,
  input wire logic clr_in,
  output int shoot_out,
  output int gap_out
);
  initial begin
    shoot_out = 0;
    gap_out = 0;
  end
  always @(posedge clk_sys_in) begin
    if (clr_in) begin
      shoot_out <= 0;
      gap_out <= 0;
    end else begin
      // both switches on is a short through the bridge
      if (hi_in === 1'b1 && lo_in === 1'b1) begin
        shoot_out <= shoot_out + 1;
      end
      // both off is the dead gap that lets a switch turn off first
      if (hi_in === 1'b0 && lo_in === 1'b0) begin
        gap_out <= gap_out + 1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/pwmdz_tb_top.sv
// Purpose: register-level test of the four-channel pwm block
// Assumes: 40 MHz clock, one-cycle strobes, read data one cycle after the strobe
// Notes: duty is measured over whole periods, so the start phase does not matter
`timescale 1ns/1ps
`default_nettype none
module pwmdz_tb_top;
  import pwmdz_pkg::*;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [AW-1:0] addr_in = 8'h00;
  logic [DW-1:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [DW-1:0] rdata_out;
  logic [NCH-1:0] pwm_out;
  logic [NCH-1:0] ch_irq_out;
  logic irq_out;
  logic clr = 1'b0;
  int fails = 0;
  int checks_done = 0;
  int shoot;
  int gap;
  pwmdz_top u_pwmdz_top (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pwm_out(pwm_out),
    .ch_irq_out(ch_irq_out), .irq_out(irq_out));
  pwmdz_power_stage u_pwmdz_power_stage (.clk_sys_in(clk_sys_in), .hi_in(pwm_out[2]),
    .lo_in(pwm_out[3]), .clr_in(clr), .shoot_out(shoot), .gap_out(gap));
  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic complete_run();
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_sys_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string what);
    @(posedge clk_sys_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 chk(what, exp, rdata_out);
  endtask
  task automatic sample(input int n, input int ch, output int ones);
    ones = 0;
    repeat (n) begin
      @(posedge clk_sys_in);
      #1 ones += int'(pwm_out[ch]);
    end
  endtask
  // reload is always 7, so one period is 8 channel ticks
  task automatic duty(input int ch, input int pre, input int sel, input int cmp, input int n, input int exp);
    int ones;
    wr(OFS_CTRL, 32'h0);
    wr(OFS_PRE, DW'(pre) << (8 * (ch / 2)));
    wr(OFS_SEL, DW'(sel) << (SEL_STRIDE * ch));
    wr(OFS_CH_BASE + AW'(16 * ch), 32'h7);
    wr(OFS_CH_BASE + AW'(16 * ch) + 8'h04, DW'(cmp));
    wr(OFS_CTRL, 32'h11 << ch);
    sample(n / 5, ch, ones);
    sample(n, ch, ones);
    chk("duty high cycles", DW'(exp), DW'(ones));
    chk("masked request", 32'h0, DW'(ch_irq_out));
    wr(OFS_CTRL, 32'h0);
    rd(OFS_IFLAG, 32'h1 << ch, "zero flag");
  endtask
  initial begin
    int i;
    int same;
    repeat (12) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    #1 chk("pins after reset", 32'h0, DW'(pwm_out));
    rd(OFS_CTRL, 32'h0, "control reset");
    rd(OFS_PRE, 32'h0, "prescale reset");
    rd(OFS_CH_BASE, 32'h0, "reload reset");
    rd(OFS_CH_BASE + 8'h04, 32'h0, "compare reset");
    wr(8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h0, "unmapped word");
    duty(0, 0, 0, 3, 80, 40);
    duty(1, 0, 1, 3, 160, 80);
    duty(2, 0, 2, 1, 320, 240);
    duty(3, 0, 3, 3, 640, 320);
    duty(1, 0, 4, 3, 1280, 640);
    duty(2, 2, 0, 3, 240, 120);
    // one-shot run of channel three with its request let through
    wr(OFS_PRE, 32'h0);
    wr(OFS_IEN, 32'h8);
    wr(OFS_CH_BASE + 8'h30, 32'h4);
    wr(OFS_CTRL, 32'h8);
    for (i = 0; i < 100 && ch_irq_out[3] !== 1'b1; i++) begin
      @(posedge clk_sys_in);
    end
    if (i == 100) begin
      fails++;
      complete_run();
    end
    #1 chk("one-shot request", 32'h8, DW'(ch_irq_out));
    chk("summary request", 32'h1, DW'(irq_out));
    rd(OFS_CH_BASE + 8'h38, 32'h0, "halted count");
    wr(OFS_IFLAG, 32'h8);
    repeat (2) @(posedge clk_sys_in);
    #1 chk("cleared request", 32'h0, DW'(irq_out));
    repeat (40) @(posedge clk_sys_in);
    rd(OFS_IFLAG, 32'h0, "single one-shot flag");
    // pair one with a two-tick gap, pair zero with no gap
    wr(OFS_CTRL, 32'h0);
    wr(OFS_DZ, 32'h0000_0200);
    wr(OFS_CH_BASE + 8'h20, 32'h7);
    wr(OFS_CH_BASE + 8'h24, 32'h3);
    wr(OFS_CTRL, 32'h0000_0355);
    repeat (20) @(posedge clk_sys_in);
    clr <= 1'b1;
    @(posedge clk_sys_in);
    clr <= 1'b0;
    same = 0;
    repeat (80) begin
      @(posedge clk_sys_in);
      #1 same += int'(pwm_out[0] == pwm_out[1]);
    end
    chk("pair both high", 32'h0, DW'(shoot));
    chk("pair gap seen", 32'h1, DW'(gap > 0));
    // two base edges per 8-tick period, each followed by a 2-tick gap
    chk("pair gap cycles", 32'd40, DW'(gap));
    chk("pair zero complementary", 32'h0, DW'(same));
    complete_run();
  end
endmodule
`default_nettype wire
